// [design/swmap_pkg.sv]
// Shared constants for the switch register map and startup control.
// Assumes an 8-bit register space reached through a plain strobe port.
package swmap_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int MAP_DEPTH = 128;
  localparam logic [7:0] FAMILY_IDENTIFIER_OFF = 8'h00;
  localparam logic [7:0] PART_REV_OFF = 8'h01;
  localparam logic [7:0] GLOBAL_LO = 8'h02;
  localparam logic [7:0] GLOBAL_HI = 8'h0b;
  localparam logic [7:0] RSVD_GLOBAL = 8'h0c;
  localparam logic [7:0] USER_LO = 8'h0d;
  localparam logic [7:0] USER_HI = 8'h0f;
  localparam logic [7:0] PORT1_BASE = 8'h10;
  localparam logic [7:0] PORT2_BASE = 8'h20;
  localparam logic [7:0] PORT3_BASE = 8'h30;
  localparam logic [3:0] PORT_CTRL_LAST = 4'hd;
  localparam logic [7:0] RSVD_LO = 8'h40;
  localparam logic [7:0] RSVD_HI = 8'h5f;
  localparam logic [7:0] PRIO_LO = 8'h60;
  localparam logic [7:0] PRIO_HI = 8'h67;
  localparam logic [7:0] STATION_LO = 8'h68;
  localparam logic [7:0] STATION_HI = 8'h6d;
  localparam logic [7:0] IND_CTRL_LO = 8'h6e;
  localparam logic [7:0] IND_CTRL_HI = 8'h6f;
  localparam logic [7:0] IND_DATA_LO = 8'h70;
  localparam logic [7:0] IND_DATA_HI = 8'h78;
  localparam logic [7:0] DTEST_STAT_LO = 8'h79;
  localparam logic [7:0] DTEST_STAT_HI = 8'h7a;
  localparam logic [7:0] DTEST_CTRL_LO = 8'h7b;
  localparam logic [7:0] DTEST_CTRL_HI = 8'h7c;
  localparam logic [7:0] ATEST_CTRL_LO = 8'h7d;
  localparam logic [7:0] ATEST_CTRL_HI = 8'h7e;
  localparam logic [7:0] ATEST_STAT = 8'h7f;
  localparam int PART_ID_MSB = 7;
  localparam int PART_ID_LSB = 4;
  localparam int REV_MSB = 3;
  localparam int REV_LSB = 1;
  localparam int RUN_BIT = 0;
  localparam logic RUN_RESET = 1'b1;
  localparam logic [7:0] DEFAULT_BYTE = 8'h00;
  localparam int CLK_MHZ = 125;
  localparam int MEM_TIMEOUT_NS = 1000;
  localparam int MEM_TIMEOUT_CYC = (MEM_TIMEOUT_NS * CLK_MHZ) / 1000;
  localparam int IMAGE_BYTES = 128;
  localparam logic [7:0] LOAD_FIRST = 8'h02;

  typedef enum {
    REG_RSVD, REG_RO_ID, REG_MIXED, REG_RW, REG_RO_STAT
  } swmap_kind_t;
endpackage

// [design/swmap_ld_if.sv]
// Carrier between the register core and the configuration memory loader.
// Assumes both ends share CLK.
`timescale 1ns/1ps
`default_nettype none
interface swmap_ld_if;
  logic start;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic done;
  logic loaded;
  modport ldr (input start, output wr_en, output wr_addr, output wr_data,
               output done, output loaded);
  modport core (output start, input wr_en, input wr_addr, input wr_data,
                input done, input loaded);
endinterface
`default_nettype wire

// [design/swmap_loader.sv]
// Reads the serial configuration memory one byte at a time, checks the image
// header and streams the remaining bytes into the register core.
// Assumes the memory answers a read request with MEM_ACK, or not at all.
`timescale 1ns/1ps
`default_nettype none
module swmap_loader #(
  parameter logic [7:0] FAMILY_IDENTIFIER = 8'h5a,
  parameter logic [3:0] PART_ID = 4'h3,
  parameter int TIMEOUT_CYC = swmap_pkg::MEM_TIMEOUT_CYC,
  parameter int IMG_BYTES = swmap_pkg::IMAGE_BYTES
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic ce, // Clock enable
  swmap_ld_if.ldr ld, // Core side
  output logic mem_rd_q, // Read request pulse
  output logic [7:0] mem_addr_q, // Byte address
  input wire logic mem_ack, // Byte valid
  input wire logic [7:0] mem_rdata // Byte value
);
  typedef enum {LD_IDLE, LD_REQ, LD_WAIT, LD_DONE} swmap_ld_t;
  localparam logic [15:0] TMO = 16'(TIMEOUT_CYC);
  localparam logic [7:0] LAST = 8'(IMG_BYTES - 1);
  swmap_ld_t st_q;
  logic [15:0] tmo_q;
  logic [7:0] fam_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= LD_IDLE;
      tmo_q <= 16'h0000;
      fam_q <= 8'h00;
      mem_rd_q <= 1'b0;
      mem_addr_q <= 8'h00;
      ld.wr_en <= 1'b0;
      ld.wr_addr <= 8'h00;
      ld.wr_data <= 8'h00;
      ld.done <= 1'b0;
      ld.loaded <= 1'b0;
    end else if (ce) begin
      mem_rd_q <= 1'b0;
      ld.wr_en <= 1'b0;
      case (st_q)
        LD_IDLE: begin
          if (ld.start) begin
            mem_addr_q <= 8'h00;
            st_q <= LD_REQ;
          end
        end
        LD_REQ: begin
          mem_rd_q <= 1'b1;
          tmo_q <= TMO;
          st_q <= LD_WAIT;
        end
        LD_WAIT: begin
          if (mem_ack) begin
            if (mem_addr_q == swmap_pkg::FAMILY_IDENTIFIER_OFF) begin
              fam_q <= mem_rdata;
              mem_addr_q <= mem_addr_q + 8'h01;
              st_q <= LD_REQ;
            end else if (mem_addr_q == swmap_pkg::PART_REV_OFF) begin
              // Header mismatch leaves every default untouched
              if (fam_q == FAMILY_IDENTIFIER &&
                  mem_rdata[swmap_pkg::PART_ID_MSB:swmap_pkg::PART_ID_LSB] == PART_ID) begin
                mem_addr_q <= swmap_pkg::LOAD_FIRST;
                st_q <= LD_REQ;
              end else begin
                st_q <= LD_DONE;
              end
            end else begin
              ld.wr_en <= 1'b1;
              ld.wr_addr <= mem_addr_q;
              ld.wr_data <= mem_rdata;
              if (mem_addr_q == LAST) begin
                ld.loaded <= 1'b1;
                st_q <= LD_DONE;
              end else begin
                mem_addr_q <= mem_addr_q + 8'h01;
                st_q <= LD_REQ;
              end
            end
          end else if (tmo_q == 16'h0000) begin
            // Silence on the first byte means no memory; later it truncates
            st_q <= LD_DONE;
          end else begin
            tmo_q <= tmo_q - 16'h0001;
          end
        end
        LD_DONE: begin
          ld.done <= 1'b1;
        end
        default: st_q <= LD_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [design/swmap_top.sv]
// Register map decode, storage and startup control of the switch.
// Assumes synchronous pins and a master that never waits for the slave.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module swmap_top #(
  parameter logic [7:0] FAMILY_IDENTIFIER = 8'h5a, // Arbitrary value
  parameter logic [3:0] PART_ID = 4'h3, // Arbitrary value
  parameter logic [2:0] REVISION = 3'h1, // Arbitrary value
  parameter int MEM_TIMEOUT = swmap_pkg::MEM_TIMEOUT_CYC,
  parameter int IMG_BYTES = swmap_pkg::IMAGE_BYTES
) (
  input wire logic CLK, // Core clock
  input wire logic RST_N, // Async reset, active low
  input wire logic CE, // Clock enable
  input wire logic [7:0] ADDR, // Register address
  input wire logic [7:0] WDATA, // Write data
  input wire logic WR, // Write strobe
  input wire logic RD, // Read strobe
  output logic [7:0] RDATA, // Read data, cycle after RD
  input wire logic CFG_SELECT_HI_PIN, // Configuration select, high
  input wire logic CFG_SELECT_LO_PIN, // Configuration select, low
  output logic MEM_RD, // Memory byte request
  output logic [7:0] MEM_ADDR, // Memory byte address
  input wire logic MEM_ACK, // Memory byte valid
  input wire logic [7:0] MEM_RDATA, // Memory byte
  output logic SWITCH_RUN, // Switching enabled
  output logic STARTUP_DONE, // Startup memory load finished, auto mode only
  output logic IMAGE_LOADED // Memory image was applied
);
  typedef enum {ST_STRAP, ST_LOAD, ST_PIN, ST_AUTO} swmap_st_t;

  function automatic logic in_rng(input logic [7:0] a, input logic [7:0] lo,
                                  input logic [7:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic port_ctrl(input logic [7:0] a);
    port_ctrl = (a[7:4] == swmap_pkg::PORT1_BASE[7:4] ||
                 a[7:4] == swmap_pkg::PORT2_BASE[7:4] ||
                 a[7:4] == swmap_pkg::PORT3_BASE[7:4]) &&
                (a[3:0] <= swmap_pkg::PORT_CTRL_LAST);
  endfunction

  function automatic logic port_stat(input logic [7:0] a);
    port_stat = (a[7:4] == swmap_pkg::PORT1_BASE[7:4] ||
                 a[7:4] == swmap_pkg::PORT2_BASE[7:4] ||
                 a[7:4] == swmap_pkg::PORT3_BASE[7:4]) &&
                (a[3:0] > swmap_pkg::PORT_CTRL_LAST);
  endfunction

  // One decode serves the software port, the loader and the read mux
  function automatic swmap_pkg::swmap_kind_t kind_of(input logic [7:0] a);
    swmap_pkg::swmap_kind_t k;
    k = swmap_pkg::REG_RSVD;
    if (a == swmap_pkg::FAMILY_IDENTIFIER_OFF) begin
      k = swmap_pkg::REG_RO_ID;
    end else if (a == swmap_pkg::PART_REV_OFF) begin
      k = swmap_pkg::REG_MIXED;
    end else if (in_rng(a, swmap_pkg::GLOBAL_LO, swmap_pkg::GLOBAL_HI)) begin
      k = swmap_pkg::REG_RW;
    end else if (a == swmap_pkg::RSVD_GLOBAL) begin
      k = swmap_pkg::REG_RSVD;
    end else if (in_rng(a, swmap_pkg::USER_LO, swmap_pkg::USER_HI)) begin
      k = swmap_pkg::REG_RW;
    end else if (port_ctrl(a)) begin
      k = swmap_pkg::REG_RW;
    end else if (port_stat(a)) begin
      k = swmap_pkg::REG_RO_STAT;
    end else if (in_rng(a, swmap_pkg::RSVD_LO, swmap_pkg::RSVD_HI)) begin
      k = swmap_pkg::REG_RSVD;
    end else if (in_rng(a, swmap_pkg::PRIO_LO, swmap_pkg::PRIO_HI)) begin
      k = swmap_pkg::REG_RW;
    end else if (in_rng(a, swmap_pkg::STATION_LO, swmap_pkg::STATION_HI)) begin
      k = swmap_pkg::REG_RW;
    end else if (in_rng(a, swmap_pkg::IND_CTRL_LO, swmap_pkg::IND_CTRL_HI)) begin
      k = swmap_pkg::REG_RW;
    end else if (in_rng(a, swmap_pkg::IND_DATA_LO, swmap_pkg::IND_DATA_HI)) begin
      k = swmap_pkg::REG_RW;
    end else if (in_rng(a, swmap_pkg::DTEST_STAT_LO, swmap_pkg::DTEST_STAT_HI)) begin
      k = swmap_pkg::REG_RO_STAT;
    end else if (in_rng(a, swmap_pkg::DTEST_CTRL_LO, swmap_pkg::DTEST_CTRL_HI)) begin
      k = swmap_pkg::REG_RW;
    end else if (in_rng(a, swmap_pkg::ATEST_CTRL_LO, swmap_pkg::ATEST_CTRL_HI)) begin
      k = swmap_pkg::REG_RW;
    end else if (a == swmap_pkg::ATEST_STAT) begin
      k = swmap_pkg::REG_RO_STAT;
    end
    kind_of = k;
  endfunction

  swmap_ld_if ld_if ();

  swmap_st_t st_q;
  logic run_q;
  logic [7:0] map_q [swmap_pkg::MAP_DEPTH];
  logic [7:0] rdata_q;
  logic switch_run_q;
  logic start_q;
  logic sw_wr_ok;
  logic ld_wr_ok;
  logic [7:0] rd_value;

  assign ld_if.start = start_q;

  swmap_loader #(
    .FAMILY_IDENTIFIER(FAMILY_IDENTIFIER),
    .PART_ID(PART_ID),
    .TIMEOUT_CYC(MEM_TIMEOUT),
    .IMG_BYTES(IMG_BYTES)
  ) u_loader (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .ld(ld_if),
    .mem_rd_q(MEM_RD),
    .mem_addr_q(MEM_ADDR),
    .mem_ack(MEM_ACK),
    .mem_rdata(MEM_RDATA)
  );

  // Only plain read-write bytes take data; a loader write blocks any software write in the same cycle
  assign sw_wr_ok = WR && kind_of(ADDR) == swmap_pkg::REG_RW && !ld_if.wr_en;
  assign ld_wr_ok = ld_if.wr_en && kind_of(ld_if.wr_addr) == swmap_pkg::REG_RW;

  // Strapped selection is caught once, after reset release
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= ST_STRAP;
      start_q <= 1'b0;
    end else if (CE) begin
      start_q <= 1'b0;
      case (st_q)
        ST_STRAP: begin
          if (!CFG_SELECT_HI_PIN && !CFG_SELECT_LO_PIN) begin
            start_q <= 1'b1;
            st_q <= ST_LOAD;
          end else begin
            st_q <= ST_PIN;
          end
        end
        ST_LOAD: begin
          if (ld_if.done) begin
            st_q <= ST_AUTO;
          end
        end
        ST_PIN: st_q <= ST_PIN;
        ST_AUTO: st_q <= ST_AUTO;
        default: st_q <= ST_STRAP;
      endcase
    end
  end

  // Run control bit at offset 0x01
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      run_q <= swmap_pkg::RUN_RESET;
    end else if (CE) begin
      if (WR && !ld_if.wr_en && ADDR == swmap_pkg::PART_REV_OFF) begin
        run_q <= WDATA[swmap_pkg::RUN_BIT];
      end
    end
  end

  // Switching gate: pin mode follows the run bit, auto mode follows the loader
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      switch_run_q <= 1'b0;
    end else if (CE) begin
      case (st_q)
        ST_PIN: switch_run_q <= run_q;
        ST_AUTO: switch_run_q <= 1'b1;
        default: switch_run_q <= 1'b0;
      endcase
    end
  end

  // Byte storage; read-only and reserved bytes keep their default
  genvar gi;
  generate
    for (gi = 0; gi < swmap_pkg::MAP_DEPTH; gi++) begin : g_map
      localparam logic [7:0] IDX = 8'(gi);
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          map_q[gi] <= swmap_pkg::DEFAULT_BYTE;
        end else if (CE) begin
          if (ld_wr_ok && ld_if.wr_addr == IDX) begin
            map_q[gi] <= ld_if.wr_data;
          end else if (sw_wr_ok && ADDR == IDX) begin
            map_q[gi] <= WDATA;
          end
        end
      end
    end
  endgenerate

  always_comb begin
    rd_value = 8'h00;
    case (kind_of(ADDR))
      swmap_pkg::REG_RO_ID: rd_value = FAMILY_IDENTIFIER;
      swmap_pkg::REG_MIXED: begin
        rd_value[swmap_pkg::PART_ID_MSB:swmap_pkg::PART_ID_LSB] = PART_ID;
        rd_value[swmap_pkg::REV_MSB:swmap_pkg::REV_LSB] = REVISION;
        rd_value[swmap_pkg::RUN_BIT] = run_q;
      end
      swmap_pkg::REG_RW: rd_value = map_q[ADDR[6:0]];
      swmap_pkg::REG_RO_STAT: rd_value = map_q[ADDR[6:0]];
      swmap_pkg::REG_RSVD: rd_value = 8'h00;
      default: rd_value = 8'h00;
    endcase
  end

  // Data stand for exactly the cycle after the strobe
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 8'h00;
    end else if (CE) begin
      rdata_q <= RD ? rd_value : 8'h00;
    end
  end

  assign RDATA = rdata_q;
  assign SWITCH_RUN = switch_run_q;
  assign STARTUP_DONE = ld_if.done;
  assign IMAGE_LOADED = ld_if.loaded;
endmodule
`default_nettype wire

// [tb/swmap_top_chk.sv]
// Port checker for swmap_top: register answers, run control, startup order.
// Bound to swmap_top; request checks qualify on CE, which the bench drops briefly.
`timescale 1ns/1ps
`default_nettype none
module swmap_top_chk #(
  parameter logic [7:0] FAMILY_IDENTIFIER = 8'h5a, // Arbitrary value
  parameter logic [3:0] PART_ID = 4'h3, // Arbitrary value
  parameter logic [2:0] REVISION = 3'h1 // Arbitrary value
) (
  input wire logic CLK, // Clock
  input wire logic RST_N, // Reset
  input wire logic CE, // Enable
  input wire logic [7:0] ADDR, // Address
  input wire logic [7:0] WDATA, // Write data
  input wire logic WR, // Write
  input wire logic RD, // Read
  input wire logic [7:0] RDATA, // Read data
  input wire logic CFG_SELECT_HI_PIN, // Strap
  input wire logic CFG_SELECT_LO_PIN, // Strap
  input wire logic MEM_RD, // Request
  input wire logic [7:0] MEM_ADDR, // Byte address
  input wire logic MEM_ACK, // Byte valid
  input wire logic [7:0] MEM_RDATA, // Byte
  input wire logic SWITCH_RUN, // Running
  input wire logic STARTUP_DONE, // Loader done
  input wire logic IMAGE_LOADED // Image applied
);
  logic run_q;
  logic pin_mode;
  logic rsvd;
  assign pin_mode = CFG_SELECT_HI_PIN || CFG_SELECT_LO_PIN;
  assign rsvd = ADDR[7] || ADDR == 8'h0c || ADDR inside {[8'h40:8'h5f]};
  // Shadow of the run bit, written only by software at offset 0x01
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      run_q <= 1'b1;
    end else if (CE && WR && ADDR == 8'h01) begin
      run_q <= WDATA[0];
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  rsvd_read_zero_a: assert property (RD && CE && rsvd |=> RDATA == 8'h00)
    else $error("reserved read not zero");
  family_read_a: assert property (RD && CE && ADDR == 8'h00 |=> RDATA == FAMILY_IDENTIFIER)
    else $error("family identifier wrong");
  part_rev_read_a: assert property (RD && CE && ADDR == 8'h01 |=>
    RDATA[7:1] == {PART_ID, REVISION}) else $error("part or revision wrong");
  run_bit_read_a: assert property (RD && CE && ADDR == 8'h01 |=> RDATA[0] == $past(run_q))
    else $error("run bit read wrong");
  mem_pulse_a: assert property (MEM_RD |=> !MEM_RD)
    else $error("memory request longer than one cycle");
  auto_wait_a: assert property (SWITCH_RUN && !pin_mode |-> STARTUP_DONE)
    else $error("auto start before memory attempt");
  // Done reaches the mode machine one cycle late, so the gate opens two cycles after done
  image_order_a: assert property ($rose(IMAGE_LOADED) |->
    !SWITCH_RUN ##1 STARTUP_DONE && !SWITCH_RUN ##2 SWITCH_RUN)
    else $error("image not applied before start");
  run_stop_a: assert property (pin_mode && !run_q && !$past(run_q, 3) |-> !SWITCH_RUN)
    else $error("switch runs with run bit clear");
  cover property (IMAGE_LOADED && SWITCH_RUN);
  cover property (STARTUP_DONE && !IMAGE_LOADED);
  cover property (pin_mode && $fell(run_q));
endmodule
bind swmap_top swmap_top_chk #(.FAMILY_IDENTIFIER(FAMILY_IDENTIFIER), .PART_ID(PART_ID), .REVISION(REVISION))
  swmap_top_chk_inst (.CLK(CLK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .CFG_SELECT_HI_PIN(CFG_SELECT_HI_PIN),
  .CFG_SELECT_LO_PIN(CFG_SELECT_LO_PIN), .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR),
  .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .SWITCH_RUN(SWITCH_RUN),
  .STARTUP_DONE(STARTUP_DONE), .IMAGE_LOADED(IMAGE_LOADED));
`default_nettype wire

// [tb/swmap_mem_model.sv]
// Model of the serial configuration memory, four-byte image.
// Answers each request after a set delay, or never when absent.
`timescale 1ns/1ps
`default_nettype none
module swmap_mem_model (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic present, // Memory fitted
  input wire logic [31:0] image, // Byte 0 lowest
  input wire logic [3:0] delay, // Answer delay
  input wire logic mem_rd, // Request
  input wire logic [7:0] mem_addr, // Byte address
  output logic mem_ack, // Byte valid
  output logic [7:0] mem_rdata // Byte
);
  logic busy_q;
  logic [3:0] cnt_q;
  logic [7:0] addr_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      addr_q <= 8'h00;
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
    end else begin
      mem_ack <= 1'b0;
      // Data is not valid outside the answer, so keep it moving
      mem_rdata <= ~mem_rdata;
      if (mem_rd && present) begin
        busy_q <= 1'b1;
        cnt_q <= delay;
        addr_q <= mem_addr;
      end else if (busy_q && cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        mem_ack <= 1'b1;
        mem_rdata <= image[addr_q[1:0]*8 +: 8];
      end
    end
  end
endmodule
`default_nettype wire

// [tb/swmap_top_test.sv]
// Self-checking bench for swmap_top: map decode, run control, startup.
// Drives register port and straps; the memory model answers the loader.
`timescale 1ns/1ps
`default_nettype none
module swmap_top_test;
  localparam logic [7:0] FAM = 8'h5a; // Arbitrary value
  localparam logic [3:0] PART = 4'h3; // Arbitrary value
  localparam logic [2:0] REV = 3'h1; // Arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sel_hi = 1'b1;
  logic sel_lo = 1'b1;
  logic present = 1'b0;
  logic [31:0] image = 32'h0;
  logic [3:0] delay = 4'h1;
  logic [7:0] rdata;
  logic [7:0] mem_addr;
  logic [7:0] mem_rdata;
  logic mem_rd;
  logic mem_ack;
  logic sw_run;
  logic st_done;
  logic img_ld;
  int fail_count = 0;
  int total_checks = 0;
  swmap_top #(.FAMILY_IDENTIFIER(FAM), .PART_ID(PART), .REVISION(REV), .MEM_TIMEOUT(4), .IMG_BYTES(4))
    swmap_top_inst (.CLK(clk), .RST_N(rst_n), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .CFG_SELECT_HI_PIN(sel_hi), .CFG_SELECT_LO_PIN(sel_lo),
    .MEM_RD(mem_rd), .MEM_ADDR(mem_addr), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata),
    .SWITCH_RUN(sw_run), .STARTUP_DONE(st_done), .IMAGE_LOADED(img_ld));
  swmap_mem_model swmap_mem_model_inst (.clk(clk), .rst_n(rst_n), .present(present),
    .image(image), .delay(delay), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic do_reset(input logic hi, input logic lo);
    @(posedge clk);
    rst_n <= 1'b0;
    sel_hi <= hi;
    sel_lo <= lo;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  function automatic logic [7:0] exp_map(input logic [7:0] a);
    if (a == 8'h00) return FAM;
    if (a inside {[8'h02:8'h0b], [8'h0d:8'h0f], [8'h60:8'h78], [8'h7b:8'h7e]}) return a ^ 8'h5c;
    if (a[7:4] inside {4'h1, 4'h2, 4'h3} && a[3:0] <= 4'hd) return a ^ 8'h5c;
    return 8'h00;
  endfunction
  task automatic t_run(input logic hi, input logic lo);
    logic [7:0] d;
    do_reset(hi, lo);
    repeat (4) @(posedge clk);
    #1 chk("switch_run", 8'h01, {7'h0, sw_run});
    wr_reg(8'h01, 8'hfe);
    repeat (3) @(posedge clk);
    #1 chk("switch_run", 8'h00, {7'h0, sw_run});
    rd_reg(8'h01, d);
    chk("part_revision_reg", {PART, REV, 1'b0}, d);
    repeat (20) @(posedge clk);
    #1 chk("switch_run", 8'h00, {7'h0, sw_run});
    wr_reg(8'h01, 8'h01);
    repeat (3) @(posedge clk);
    #1 chk("switch_run", 8'h01, {7'h0, sw_run});
    // A write while the enable is low must leave the run bit alone
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(8'h01, 8'h00);
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("switch_run", 8'h01, {7'h0, sw_run});
    rd_reg(8'h01, d);
    chk("part_revision_reg", {PART, REV, 1'b1}, d);
  endtask
  task automatic t_map();
    logic [7:0] d;
    do_reset(1'b1, 1'b1);
    for (int a = 0; a < 256; a++) begin
      if (a != 1) wr_reg(8'(a), 8'(a) ^ 8'h5c);
    end
    for (int a = 0; a < 256; a++) begin
      if (a != 1) begin
        rd_reg(8'(a), d);
        chk($sformatf("reg_%h", a), exp_map(8'(a)), d);
      end
    end
  endtask
  task automatic t_auto(input logic p, input logic [31:0] img, input logic [3:0] dl,
    input logic ok);
    logic [7:0] d;
    present <= p;
    image <= img;
    delay <= dl;
    do_reset(1'b0, 1'b0);
    wr_reg(8'h01, 8'h00);
    for (int n = 0; n < 300 && st_done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (st_done !== 1'b1) begin
      fail_count++;
      $display("MISMATCH startup_done expected 1 seen %b", st_done);
      wrap_up();
    end
    chk("image_loaded", {7'h0, ok}, {7'h0, img_ld});
    // Last byte asked: 3 for a full image, 1 after a header read, 0 with no memory
    chk("mem_addr", ok ? 8'h03 : {7'h0, p}, mem_addr);
    // Done is seen by the mode machine a cycle later, then the gate opens
    repeat (2) @(posedge clk);
    #1 chk("switch_run", 8'h01, {7'h0, sw_run});
    rd_reg(8'h02, d);
    chk("reg_02", ok ? img[23:16] : 8'h00, d);
    rd_reg(8'h03, d);
    chk("reg_03", ok ? img[31:24] : 8'h00, d);
  endtask
  initial begin
    t_run(1'b0, 1'b1);
    t_run(1'b1, 1'b0);
    t_run(1'b1, 1'b1);
    t_map();
    t_auto(1'b0, 32'h2211305a, 4'h1, 1'b0);
    t_auto(1'b1, 32'h2211305a, 4'h1, 1'b1);
    t_auto(1'b1, 32'h2211305b, 4'h2, 1'b0);
    t_auto(1'b1, 32'h2211405a, 4'h2, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
